// ===== include/event_status_defs.svh
`ifndef EVENT_STATUS_DEFS_SVH
`define EVENT_STATUS_DEFS_SVH

// ==========================================================================
// Event register bit positions
`define BIT_OP_COMPLETE     0
`define BIT_QUERY_ERR       2
`define BIT_DEVICE_ERR      3
`define BIT_EXEC_ERR        4
`define BIT_CMD_ERR         5
`define BIT_POWER_ON        7
`define UNUSED_EVENT_BITS   8'h42

// ==========================================================================
// Reset values
`define FLAGS_RESET         8'h80
`define MASK_RESET          8'h00

// ==========================================================================
// Identification reply layout
`define IDN_MAX_CHARS       72
`define NAME_CHARS          8
`define SERIAL_CHARS        10
`define VERSION_CHARS       5
`define VERSION_POINT_POS   2

// ==========================================================================
// ASCII codes
`define ASCII_ZERO          8'h30
`define ASCII_NINE          8'h39
`define ASCII_COMMA         8'h2C
`define ASCII_POINT         8'h2E

`endif

// ===== include/event_status_pkg.sv
package event_status_pkg;

  // ========================================================================
  // Common commands delivered by the message parser
  typedef enum logic [2:0] {
    CMD_NONE         = 3'h0,
    CMD_ESE_SET      = 3'h1,
    CMD_ESE_QUERY    = 3'h2,
    CMD_ESR_QUERY    = 3'h3,
    CMD_OPC          = 3'h4,
    CMD_IDN_QUERY    = 3'h5,
    CMD_CLEAR_STATUS = 3'h6,
    CMD_RESET        = 3'h7
  } cmd_t;

  // ========================================================================
  // Reply sequencer states
  typedef enum logic [2:0] {
    ST_IDLE     = 3'h0,
    ST_NUM_TX   = 3'h1,
    ST_IDN_ADDR = 3'h2,
    ST_IDN_LOAD = 3'h3,
    ST_IDN_TX   = 3'h4
  } reply_state_t;

  // ========================================================================
  // Whole state of the unit
  typedef struct packed {
    reply_state_t    state;
    logic [7:0]      flags;
    logic [7:0]      mask;
    logic [7:0]      snap;
    logic            is_esr;
    logic            opc_pending;
    logic [2:0][7:0] digits;
    logic [1:0]      ndig;
    logic [1:0]      pos;
    logic [6:0]      idx;
    logic            resp_valid;
    logic [7:0]      resp_data;
    logic            resp_last;
    logic            cmd_ready;
    logic            event_summary_bit;
  } unit_state_t;

endpackage

// ===== rtl/idn_text_rom.sv
`timescale 1ns/1ps
`include "event_status_defs.svh"

module idn_text_rom #(
  parameter int              DEPTH = 34,
  parameter logic [DEPTH*8-1:0] TEXT = '0
) (
  input  wire logic       clock_i,  // Unit clock.
  input  wire logic [6:0] addr_i,   // Character index, first character at 0.
  output logic      [7:0] data_o    // Registered character.
);

  // ========================================================================
  // Registered read; first character sits in the top byte of TEXT.
  logic [7:0] data_d;
  logic [7:0] data_q;
  int         sel;

  always_comb begin
    sel    = DEPTH - 1 - int'(addr_i);
    data_d = 8'h00;
    if (int'(addr_i) < DEPTH) begin
      data_d = TEXT[sel*8 +: 8];
    end
  end

  always_ff @(posedge clock_i) begin
    data_q <= data_d;
  end

  assign data_o = data_q;

endmodule // idn_text_rom

// ===== rtl/standard_event_status_unit.sv
`timescale 1ns/1ps
`include "event_status_defs.svh"

// Summary of operation
// - ESE write loads the full 8-bit enable mask; omitted bits become zero.
// - ESE query replies with the enable mask as decimal 0 to 255.
// - ESR query replies with the enabled event bits as decimal 0 to 189.
// - Delivering the ESR reply clears the event register.
// - OR of enabled event bits forms the event summary bit.
// - Bits 5, 4, 3, 2 flag command, execution, device and query errors.
// - Bit 7 flags power on; bit 0 flags operation complete.
// - Bits 6 and 1 never carry an event.
// - OPC sets bit 0 once pending operations have finished.
// - OPC overlaps: later commands stay accepted while it waits.
// - IDN query sends maker, model, serial and version, comma separated.
// - Serial number field holds at most 10 digits.
// - Version field is two digits, a point, two digits.
// - Identification reply never exceeds 72 characters.
// - Clear status zeroes events and summary, keeps the enable mask.
// - Device reset leaves the enable mask unchanged.

module standard_event_status_unit
  import event_status_pkg::*;
#(
  parameter logic [`NAME_CHARS*8-1:0]    MAKER_NAME    = "VENDORCO",   // Arbitrary.
  parameter logic [`NAME_CHARS*8-1:0]    MODEL_NAME    = "SIGGEN01",   // Arbitrary.
  parameter logic [`SERIAL_CHARS*8-1:0]  SERIAL_NUMBER = "0000000001", // Arbitrary.
  parameter logic [`VERSION_CHARS*8-1:0] SW_VERSION    = "01.00"       // Arbitrary.
) (
  input  wire logic       clock_i,           // Unit clock, 250 MHz.
  input  wire logic       rst_n_i,           // Synchronous reset, active low.
  input  wire logic       cmd_valid_i,       // Parsed command present.
  input  wire cmd_t       cmd_code_i,        // Parsed command code.
  input  wire logic [7:0] cmd_arg_i,         // Numeric argument of the ESE write.
  output logic            cmd_ready_o,       // Command can be taken.
  output logic            resp_valid_o,      // Reply character present.
  output logic      [7:0] resp_data_o,       // Reply character, ASCII.
  output logic            resp_last_o,       // Last character of the reply.
  input  wire logic       resp_ready_i,      // Reply character taken.
  input  wire logic       cmd_error_i,       // Command error event pulse.
  input  wire logic       exec_error_i,      // Execution error event pulse.
  input  wire logic       dev_error_i,       // Device-dependent error event pulse.
  input  wire logic       query_error_i,     // Query error event pulse.
  input  wire logic       ops_busy_i,        // Selected device operations pending.
  output logic      [7:0] event_flags_o,     // Event register contents.
  output logic      [7:0] event_mask_o,      // Event enable mask contents.
  output logic            event_summary_bit_o // Summary bit for status byte bit 5.
);

  // ========================================================================
  // Identification text
  localparam int IDN_LEN = 2 * `NAME_CHARS + `SERIAL_CHARS + `VERSION_CHARS + 3;
  localparam int VER_START = IDN_LEN - `VERSION_CHARS;
  localparam logic [IDN_LEN*8-1:0] IDN_TEXT = {MAKER_NAME, `ASCII_COMMA, MODEL_NAME,
    `ASCII_COMMA, SERIAL_NUMBER, `ASCII_COMMA, SW_VERSION};
  localparam logic [6:0] IDN_LAST = 7'(IDN_LEN - 1);

  unit_state_t s_q;
  unit_state_t s_d;
  logic [7:0]  rom_data;
  logic        take;
  logic        delivered;
  logic        opc_done;
  logic [7:0]  ev_set;
  logic [7:0]  ev_clr;
  logic [7:0]  num_val;
  logic [7:0]  hund;
  logic [7:0]  tens;
  logic [7:0]  ones;

  idn_text_rom #(
    .DEPTH (IDN_LEN),
    .TEXT  (IDN_TEXT)
  ) u_rom (
    .clock_i (clock_i),
    .addr_i  (s_q.idx),
    .data_o  (rom_data)
  );

  // ========================================================================
  // Next state
  always_comb begin
    s_d       = s_q;
    take      = cmd_valid_i && s_q.cmd_ready;
    delivered = s_q.resp_valid && resp_ready_i;
    opc_done  = s_q.opc_pending && !ops_busy_i;
    num_val   = (cmd_code_i == CMD_ESE_QUERY) ? s_q.mask : (s_q.flags & s_q.mask);
    hund      = num_val / 8'h64;
    tens      = (num_val / 8'h0A) % 8'h0A;
    ones      = num_val % 8'h0A;

    // Events set sticky bits; unused positions never load.
    ev_set                   = 8'h00;
    ev_set[`BIT_CMD_ERR]     = cmd_error_i;
    ev_set[`BIT_EXEC_ERR]    = exec_error_i;
    ev_set[`BIT_DEVICE_ERR]  = dev_error_i;
    ev_set[`BIT_QUERY_ERR]   = query_error_i;
    ev_set[`BIT_OP_COMPLETE] = opc_done;
    ev_clr                   = 8'h00;

    if (opc_done) begin
      s_d.opc_pending = 1'b0;
    end

    case (s_q.state)
      ST_IDLE: begin
        if (take) begin
          case (cmd_code_i)
            CMD_ESE_SET: begin
              s_d.mask = cmd_arg_i;
            end
            CMD_ESE_QUERY, CMD_ESR_QUERY: begin
              s_d.is_esr = (cmd_code_i == CMD_ESR_QUERY);
              s_d.snap   = s_q.flags;
              s_d.pos    = 2'h0;
              if (num_val >= 8'h64) begin
                s_d.digits = {`ASCII_ZERO + ones, `ASCII_ZERO + tens, `ASCII_ZERO + hund};
                s_d.ndig   = 2'h3;
              end else if (num_val >= 8'h0A) begin
                s_d.digits = {8'h00, `ASCII_ZERO + ones, `ASCII_ZERO + tens};
                s_d.ndig   = 2'h2;
              end else begin
                s_d.digits = {8'h00, 8'h00, `ASCII_ZERO + ones};
                s_d.ndig   = 2'h1;
              end
              s_d.resp_valid = 1'b1;
              s_d.resp_data  = s_d.digits[0];
              s_d.resp_last  = (s_d.ndig == 2'h1);
              s_d.state      = ST_NUM_TX;
            end
            CMD_OPC: begin
              s_d.opc_pending = 1'b1;
            end
            CMD_IDN_QUERY: begin
              s_d.idx   = 7'h00;
              s_d.state = ST_IDN_ADDR;
            end
            CMD_CLEAR_STATUS: begin
              ev_clr          = 8'hFF;
              s_d.opc_pending = 1'b0;
            end
            CMD_RESET: begin
              s_d.opc_pending = 1'b0;
            end
            default: begin
            end
          endcase
        end
      end
      ST_NUM_TX: begin
        if (delivered) begin
          if (s_q.resp_last) begin
            s_d.resp_valid = 1'b0;
            s_d.state      = ST_IDLE;
            if (s_q.is_esr) begin
              ev_clr = s_q.snap;
            end
          end else begin
            s_d.pos       = s_q.pos + 2'h1;
            s_d.resp_data = s_q.digits[s_d.pos];
            s_d.resp_last = (s_d.pos == s_q.ndig - 2'h1);
          end
        end
      end
      ST_IDN_ADDR: begin
        s_d.state = ST_IDN_LOAD;
      end
      ST_IDN_LOAD: begin
        s_d.resp_valid = 1'b1;
        s_d.resp_data  = rom_data;
        s_d.resp_last  = (s_q.idx == IDN_LAST);
        s_d.state      = ST_IDN_TX;
      end
      ST_IDN_TX: begin
        if (delivered) begin
          s_d.resp_valid = 1'b0;
          if (s_q.resp_last) begin
            s_d.state = ST_IDLE;
          end else begin
            s_d.idx   = s_q.idx + 7'h01;
            s_d.state = ST_IDN_ADDR;
          end
        end
      end
      default: begin
        s_d.state      = ST_IDLE;
        s_d.resp_valid = 1'b0;
      end
    endcase

    // A new event wins over a clear in the same cycle.
    s_d.flags     = ((s_q.flags & ~ev_clr) | ev_set) & ~`UNUSED_EVENT_BITS;
    s_d.cmd_ready = (s_d.state == ST_IDLE);
    s_d.event_summary_bit = |(s_d.flags & s_d.mask);
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      s_q             <= '0;
      s_q.state       <= ST_IDLE;
      s_q.flags       <= `FLAGS_RESET;
      s_q.mask        <= `MASK_RESET;
      s_q.cmd_ready   <= 1'b1;
      s_q.event_summary_bit <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign cmd_ready_o         = s_q.cmd_ready;
  assign resp_valid_o        = s_q.resp_valid;
  assign resp_data_o         = s_q.resp_data;
  assign resp_last_o         = s_q.resp_last;
  assign event_flags_o       = s_q.flags;
  assign event_mask_o        = s_q.mask;
  assign event_summary_bit_o = s_q.event_summary_bit;

  // ========================================================================
  // Checks
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  logic no_events;
  assign no_events = !(cmd_error_i || exec_error_i || dev_error_i || query_error_i || opc_done);

  // Last character of an event register reading is being taken in this cycle.
  logic esr_end;
  assign esr_end = s_q.state == ST_NUM_TX && s_q.is_esr && delivered && s_q.resp_last;

  sequence esr_taken;
    take && cmd_code_i == CMD_ESR_QUERY;
  endsequence

  sequence esr_done;
    esr_end && no_events;
  endsequence

  property p_ese_load;
    take && cmd_code_i == CMD_ESE_SET |=> s_q.mask == $past(cmd_arg_i);
  endproperty
  a_ese_load: assert property (p_ese_load) else $error("ESE write not loaded");

  property p_ese_query_zero;
    take && cmd_code_i == CMD_ESE_QUERY && s_q.mask == 8'h00
      |=> resp_valid_o && resp_data_o == `ASCII_ZERO && resp_last_o;
  endproperty
  a_ese_query_zero: assert property (p_ese_query_zero) else $error("ESE query reply wrong");

  // Bits 6 and 1 never carry an event, so a three-digit reading is at most 189 and opens with 1.
  property p_esr_reply;
    esr_taken ##0 (num_val >= 8'h64)
      |=> resp_valid_o && resp_data_o == 8'h31 && !resp_last_o;
  endproperty
  a_esr_reply: assert property (p_esr_reply) else $error("ESR reply first digit wrong");

  property p_esr_clear;
    esr_done |=> (s_q.flags & $past(s_q.snap)) == 8'h00 && s_q.state == ST_IDLE;
  endproperty
  a_esr_clear: assert property (p_esr_clear) else $error("ESR read did not clear");

  property p_summary;
    event_summary_bit_o == |(event_flags_o & event_mask_o);
  endproperty
  a_summary: assert property (p_summary) else $error("Summary bit mismatch");

  property p_cmd_error;
    cmd_error_i |=> event_flags_o[`BIT_CMD_ERR];
  endproperty
  a_cmd_error: assert property (p_cmd_error) else $error("Command error not flagged");

  property p_power_on;
    $rose(rst_n_i) |-> event_flags_o[`BIT_POWER_ON];
  endproperty
  a_power_on: assert property (p_power_on) else $error("Power-on flag missing");

  property p_unused;
    (event_flags_o & `UNUSED_EVENT_BITS) == 8'h00;
  endproperty
  a_unused: assert property (p_unused) else $error("Unused event bit set");

  property p_opc_done;
    s_q.opc_pending && !ops_busy_i |=> event_flags_o[`BIT_OP_COMPLETE];
  endproperty
  a_opc_done: assert property (p_opc_done) else $error("OPC completion lost");

  property p_opc_overlap;
    take && cmd_code_i == CMD_OPC && ops_busy_i |=> cmd_ready_o && s_q.opc_pending;
  endproperty
  a_opc_overlap: assert property (p_opc_overlap) else $error("OPC blocked commands");

  property p_version_chars;
    s_q.state == ST_IDN_TX && int'(s_q.idx) >= VER_START |->
      (int'(s_q.idx) == VER_START + `VERSION_POINT_POS) ? resp_data_o == `ASCII_POINT :
      (resp_data_o >= `ASCII_ZERO && resp_data_o <= `ASCII_NINE);
  endproperty
  a_version_chars: assert property (p_version_chars) else $error("Bad version field");

  property p_idn_len;
    s_q.state == ST_IDN_TX |-> int'(s_q.idx) < `IDN_MAX_CHARS && s_q.idx <= IDN_LAST;
  endproperty
  a_idn_len: assert property (p_idn_len) else $error("Identification reply too long");

  property p_cls;
    take && cmd_code_i == CMD_CLEAR_STATUS && no_events
      |=> event_flags_o == 8'h00 && !event_summary_bit_o && $stable(event_mask_o);
  endproperty
  a_cls: assert property (p_cls) else $error("Clear status wrong");

  property p_rst_mask;
    take && cmd_code_i == CMD_RESET |=> $stable(event_mask_o);
  endproperty
  a_rst_mask: assert property (p_rst_mask) else $error("Reset changed mask");

  property p_sticky;
    event_flags_o[`BIT_EXEC_ERR] && !(take && cmd_code_i == CMD_CLEAR_STATUS) && !esr_end
      |=> event_flags_o[`BIT_EXEC_ERR];
  endproperty
  a_sticky: assert property (p_sticky) else $error("Event bit dropped");

endmodule // standard_event_status_unit

// ===== verification/remote_controller_model.sv
`timescale 1ns/1ps

// ==========================================================================
// Controller side: issues parsed commands and takes reply characters.
module remote_controller_model
  import event_status_pkg::*;
(
  input  wire logic       clock_i,     // Unit clock.
  input  wire logic       cmd_ready_i, // Unit can take a command.
  input  wire logic       slow_i,      // Drop reply ready on every other cycle.
  output cmd_t            cmd_code_o,  // Command code.
  output logic      [7:0] cmd_arg_o,   // Enable argument.
  output logic            cmd_valid_o, // Command present.
  output logic            resp_ready_o // Reply character taken.
);
  initial begin
    cmd_valid_o  = 1'b0;
    cmd_code_o   = CMD_NONE;
    cmd_arg_o    = 8'h5A;
  end

  always @(posedge clock_i) begin
    resp_ready_o <= slow_i ? ~resp_ready_o : 1'b1;
  end

  // The argument already is the sum of the weights of the enabled bits.
  task automatic send(input cmd_t code, input logic [7:0] arg, output logic taken);
    int n;
    n = 0;
    @(posedge clock_i);
    cmd_valid_o <= 1'b1;
    cmd_code_o  <= code;
    cmd_arg_o   <= arg;
    @(negedge clock_i);
    while (!cmd_ready_i && n < 300) begin
      @(negedge clock_i);
      n++;
    end
    taken = cmd_ready_i;
    @(posedge clock_i);
    cmd_valid_o <= 1'b0;
    // Idle lines are inverted so that a late sample of stale data cannot pass.
    cmd_code_o  <= cmd_t'(~cmd_code_o);
    cmd_arg_o   <= ~cmd_arg_o;
  endtask
endmodule // remote_controller_model

// ===== verification/tb.sv
`timescale 1ns/1ps

module tb
  import event_status_pkg::*;
;
  // Identity strings are arbitrary; the version sits at the top of its range.
  localparam logic [63:0]  MAKER    = "TESTMAKR";
  localparam logic [63:0]  MODEL    = "UNITGEN9";
  localparam logic [79:0]  SERIAL   = "9876543210";
  localparam logic [39:0]  SWVER    = "99.99";
  localparam logic [271:0] IDN_TEXT = {MAKER, ",", MODEL, ",", SERIAL, ",", SWVER};

  logic       clock_i;
  logic       rst_n_i;
  logic       cmd_valid;
  cmd_t       cmd_code;
  logic [7:0] cmd_arg;
  logic       cmd_ready;
  logic       resp_valid;
  logic [7:0] resp_data;
  logic       resp_last;
  logic       resp_ready;
  logic [3:0] err_pulse;
  logic       ops_busy;
  logic [7:0] flags;
  logic [7:0] mask;
  logic       summary;
  logic       slow;
  logic [8:0] exp_q[$];
  logic [8:0] note;
  logic [7:0] resp_count;
  logic [7:0] exp_flags;
  logic [7:0] v;
  logic [31:0] seed;
  int         miscompares;
  int         num_checks;

  standard_event_status_unit #(
    .MAKER_NAME(MAKER), .MODEL_NAME(MODEL), .SERIAL_NUMBER(SERIAL), .SW_VERSION(SWVER)
  ) uut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid), .cmd_code_i(cmd_code),
    .cmd_arg_i(cmd_arg), .cmd_ready_o(cmd_ready), .resp_valid_o(resp_valid),
    .resp_data_o(resp_data), .resp_last_o(resp_last), .resp_ready_i(resp_ready),
    .cmd_error_i(err_pulse[3]), .exec_error_i(err_pulse[2]), .dev_error_i(err_pulse[1]),
    .query_error_i(err_pulse[0]), .ops_busy_i(ops_busy), .event_flags_o(flags),
    .event_mask_o(mask), .event_summary_bit_o(summary)
  );

  remote_controller_model ctrl (
    .clock_i(clock_i), .cmd_ready_i(cmd_ready), .slow_i(slow), .cmd_code_o(cmd_code),
    .cmd_arg_o(cmd_arg), .cmd_valid_o(cmd_valid), .resp_ready_o(resp_ready)
  );

  always #2 clock_i = ~clock_i;

  // ========================================================================
  // Shared tasks
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    if (miscompares == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic do_cmd(input cmd_t code, input logic [7:0] arg);
    logic taken;
    ctrl.send(code, arg, taken);
    check({7'h00, taken}, 8'h01);
  endtask

  task automatic settle();
    repeat (2) @(negedge clock_i);
  endtask

  task automatic exp_num(input logic [7:0] n);
    if (n >= 8'h64) exp_q.push_back({1'b0, 8'h30 + n / 8'h64});
    if (n >= 8'h0A) exp_q.push_back({1'b0, 8'h30 + (n / 8'h0A) % 8'h0A});
    exp_q.push_back({1'b1, 8'h30 + n % 8'h0A});
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 1000) begin
      @(negedge clock_i);
      n++;
    end
    check(8'(exp_q.size()), 8'h00);
    settle();
  endtask

  task automatic pulse(input int b);
    @(posedge clock_i);
    err_pulse[b] <= 1'b1;
    @(posedge clock_i);
    err_pulse[b] <= 1'b0;
    @(negedge clock_i);
  endtask

  // ========================================================================
  // Reply monitor: every taken character is matched against the oldest note.
  always @(negedge clock_i) begin
    if (resp_valid && resp_ready) begin
      resp_count = resp_count + 8'h01;
      if (exp_q.size() == 0) begin
        miscompares++;
        $display("ERROR %0t: unexpected reply character", $time);
      end else begin
        note = exp_q.pop_front();
        check(resp_data, note[7:0]);
        check({7'h00, resp_last}, {7'h00, note[8]});
      end
    end
  end

  initial begin
    repeat (20000) @(posedge clock_i);
    miscompares++;
    $display("ERROR %0t: watchdog expired", $time);
    print_verdict();
  end

  // ========================================================================
  // Main sequence
  initial begin
    clock_i = 1'b0;
    rst_n_i = 1'b0;
    err_pulse = 4'h0;
    ops_busy = 1'b0;
    slow = 1'b0;
    resp_count = 8'h00;
    seed = 32'ha266;
    repeat (5) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(negedge clock_i);
    check(flags, 8'h80);
    check(mask, 8'h00);
    check({7'h00, summary}, 8'h00);
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : seed[7:0];
      slow <= i[0];
      do_cmd(CMD_ESE_SET, v);
      settle();
      check(mask, v);
      exp_num(v);
      do_cmd(CMD_ESE_QUERY, 8'h00);
      wait_idle();
    end
    do_cmd(CMD_ESE_SET, 8'h04);
    exp_flags = 8'h80;
    for (int b = 3; b >= 0; b--) begin
      pulse(b);
      exp_flags[b + 2] = 1'b1;
      check(flags, exp_flags);
      check({7'h00, summary}, {7'h00, b == 0});
    end
    do_cmd(CMD_ESE_SET, 8'h02);
    settle();
    check(flags, 8'hBC);
    check({7'h00, summary}, 8'h00);
    do_cmd(CMD_ESE_SET, 8'hA5);
    exp_num(8'hA4);
    do_cmd(CMD_ESR_QUERY, 8'h00);
    wait_idle();
    check(flags, 8'h00);
    @(posedge clock_i);
    ops_busy <= 1'b1;
    do_cmd(CMD_OPC, 8'h00);
    settle();
    check(flags, 8'h00);
    do_cmd(CMD_ESE_SET, 8'h01);
    settle();
    check(mask, 8'h01);
    @(posedge clock_i);
    ops_busy <= 1'b0;
    repeat (3) @(negedge clock_i);
    check(flags, 8'h01);
    check({7'h00, summary}, 8'h01);
    do_cmd(CMD_CLEAR_STATUS, 8'h00);
    settle();
    check(flags, 8'h00);
    check(mask, 8'h01);
    check({7'h00, summary}, 8'h00);
    do_cmd(CMD_RESET, 8'h00);
    settle();
    check(mask, 8'h01);
    slow <= 1'b1;
    resp_count = 8'h00;
    for (int k = 33; k >= 0; k--) exp_q.push_back({k == 0, IDN_TEXT[k*8 +: 8]});
    do_cmd(CMD_IDN_QUERY, 8'h00);
    wait_idle();
    check(resp_count, 8'h22);
    print_verdict();
  end
endmodule // tb
